/* design/sse_pkg.sv */
// Package: constants, config layout and types of the sequencing state engine
package sse_pkg;

  // Clock and timing
  localparam int CLK_MHZ      = 200;
  localparam int LOAD_US      = 20;                        // Config download latency
  localparam int LOAD_CYC     = LOAD_US * CLK_MHZ;
  localparam int DLY_UNIT_US  = 10;                        // One delay-field step
  localparam int DLY_UNIT_CYC = DLY_UNIT_US * CLK_MHZ;
  localparam int SEQ_MIN_US   = 10;
  localparam int SEQ_MAX_US   = 400000;
  localparam int TMO_MIN_US   = 100;
  localparam int TMO_MAX_US   = 400000;
  localparam logic [15:0] SEQ_MIN_U = 16'(SEQ_MIN_US / DLY_UNIT_US);
  localparam logic [15:0] SEQ_MAX_U = 16'(SEQ_MAX_US / DLY_UNIT_US);
  localparam logic [15:0] TMO_MIN_U = 16'(TMO_MIN_US / DLY_UNIT_US);
  localparam logic [15:0] TMO_MAX_U = 16'(TMO_MAX_US / DLY_UNIT_US);
  localparam int CYC_W        = 27;                        // Holds 400 ms of cycles
  localparam int LD_W         = 12;

  // Sizes
  localparam int NUM_IN     = 10;
  localparam int NUM_DIG    = 5;
  localparam int NUM_ADC    = 13;
  localparam logic [5:0] NUM_STATES = 6'h3F;               // 63 state cells

  // Register byte offsets
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_JUMP  = 12'h004;
  localparam logic [11:0] A_STATE = 12'h008;
  localparam logic [11:0] A_FLO   = 12'h00C;
  localparam logic [11:0] A_FHI   = 12'h010;
  localparam logic [11:0] A_SUVOV = 12'h014;
  localparam logic [11:0] A_SADC  = 12'h018;
  localparam logic [11:0] A_LIM   = 12'h040;
  localparam logic [11:0] A_CFG   = 12'h400;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // Reset values
  localparam logic        RUN_RST = 1'b0;
  localparam logic [12:0] LIM_RST = 13'h0000;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } sse_st_e;

  // One state definition, four words, word 0 lowest
  typedef struct packed {
    logic [15:0] mon_exp;
    logic [15:0] mon_mask;
    logic [5:0]  rsv2;
    logic [9:0]  out_lvl;
    logic [9:0]  rsv1;
    logic [5:0]  mon_next;
    logic [15:0] tmo_dly;
    logic [8:0]  rsv0;
    logic        latch_en;
    logic [5:0]  tmo_next;
    logic [15:0] seq_dly;
    logic [4:0]  rsv;
    logic [5:0]  seq_next;
    logic        seq_lvl;
    logic [3:0]  seq_sel;
  } sse_cfg_s;

  // One ADC result
  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic [11:0] code;
  } sse_adc_s;

endpackage

/* design/sse_cfg_mem.sv */
// State definition store: simple dual port, registered read data
`timescale 1ns/100ps
module sse_cfg_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            nrst_in,
  // Write port
  input  wire logic            wr_en_in,
  input  wire logic [DW/8-1:0] wr_be_in,
  input  wire logic [AW-1:0]   wr_addr_in,
  input  wire logic [DW-1:0]   wr_data_in,
  // Read port
  input  wire logic [AW-1:0]   rd_addr_in,
  output logic      [DW-1:0]   rd_data_out
);

  logic [DW-1:0] mem_r [2**AW];

  // Byte-lane writes
  always_ff @(posedge clk_in) begin
    for (int b = 0; b < DW / 8; b++) begin
      if (wr_en_in && wr_be_in[b]) begin
        mem_r[wr_addr_in][b*8 +: 8] <= wr_data_in[b*8 +: 8];
      end
    end
  end

  // Registered read
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_r[rd_addr_in];
    end
  end

endmodule

/* design/sse_engine.sv */
// Supply sequencing state engine with AXI4-Lite register slave
//
// Function
// - All warning sources OR into one warning fed to the sequence and monitor detectors.
// - Warning on ADC reading beyond its limit or a secondary monitor trip.
// - Host jump command forces an exit, through the sequence exit unless a monitor or timeout exit wins.
// - Sequence detector waits for selected input at programmed level, then exits.
// - Sequence hold delay spans 10 us to 400 ms.
// - Input must hold for the whole delay; any change restarts the timer.
// - Monitor exit fires when any selected input leaves its expected level.
// - Monitor detector has no delay at all.
// - Every exit reloads next state's definition, taking about 20 us.
// - Timeout exit when sequence exit missing within 100 us to 400 ms.
// - State output pin levels are driven at entry to that state.
// - Sample program: rail A timeout leads to disable state, pins set.
// - One sticky fault bit per supply input, split over two registers.
// - Host reads the fault bits over the register bus.
// - Fault latch captures only while the current state enables it.
// - Live undervoltage, overvoltage and ADC limit flags, never latched.
// - 63 state cells, each reachable from every other.
// - Three exits per state, each naming its own next state.
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
module sse_engine #(
  parameter int DLY_UNIT_CYC = sse_pkg::DLY_UNIT_CYC,      // Cycles per delay step
  parameter int LOAD_CYC     = sse_pkg::LOAD_CYC           // Download latency, at least 6
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  // AXI4-Lite write
  input  wire logic                 s_axi_awvalid_in,
  input  wire logic [11:0]          s_axi_awaddr_in,
  output logic                      s_axi_awready_out,
  input  wire logic                 s_axi_wvalid_in,
  input  wire logic [31:0]          s_axi_wdata_in,
  input  wire logic [3:0]           s_axi_wstrb_in,
  output logic                      s_axi_wready_out,
  output logic                      s_axi_bvalid_out,
  output logic [1:0]                s_axi_bresp_out,
  input  wire logic                 s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic                 s_axi_arvalid_in,
  input  wire logic [11:0]          s_axi_araddr_in,
  output logic                      s_axi_arready_out,
  output logic                      s_axi_rvalid_out,
  output logic [31:0]               s_axi_rdata_out,
  output logic [1:0]                s_axi_rresp_out,
  input  wire logic                 s_axi_rready_in,
  // Supply and digital inputs
  input  wire logic [9:0]           sfd_uv_in,
  input  wire logic [9:0]           sfd_ov_in,
  input  wire logic [4:0]           dual_function_input_in,
  input  wire logic [4:0]           sec_warn_in,
  input  wire sse_pkg::sse_adc_s    adc_in,
  // Output pins
  output logic [9:0]                programmable_output_pin_out
);

  localparam int LD_LAST = LOAD_CYC - 1;
  localparam int CW      = sse_pkg::CYC_W;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Clamp a nonzero delay field into range and scale to cycles
  function automatic logic [CW-1:0] dly_cyc(input logic [15:0] d,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [15:0] c;
    c = (d < lo) ? lo : ((d > hi) ? hi : d);
    if (d == 16'h0000) begin
      c = 16'h0000;
    end
    return CW'(c * DLY_UNIT_CYC);
  endfunction

  // Known register address
  function automatic logic addr_ok(input logic [11:0] a);
    logic hit;
    hit = (a == sse_pkg::A_CTRL) || (a == sse_pkg::A_JUMP) || (a == sse_pkg::A_STATE)
       || (a == sse_pkg::A_FLO) || (a == sse_pkg::A_FHI) || (a == sse_pkg::A_SUVOV)
       || (a == sse_pkg::A_SADC);
    if (a[11:6] == sse_pkg::A_LIM[11:6] && a[1:0] == 2'h0 && a[5:2] < 4'(sse_pkg::NUM_ADC)) begin
      hit = 1'b1;
    end
    if (a[11:10] == sse_pkg::A_CFG[11:10] && a[1:0] == 2'h0
        && a[9:4] < sse_pkg::NUM_STATES) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  sse_pkg::sse_st_e  st_r;
  sse_pkg::sse_cfg_s cfg_r;
  logic [5:0]        cur_r;
  logic [11:0]       ld_cnt_r;
  logic [127:0]      fetch_r;
  logic [CW-1:0]     seq_cyc_r;
  logic [CW-1:0]     tmo_cyc_r;
  logic              run_r;
  logic              jump_r;
  logic [9:0]        flt_r;
  logic [12:0]       lim_r [sse_pkg::NUM_ADC];
  logic [12:0]       adc_flag_r;
  logic [9:0]        uv_r;
  logic [9:0]        ov_r;
  logic [31:0]       mem_rd_w;
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [11:0]       awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;
  logic [9:0]        pdo_r;

  ////////////////////////////////////////////////////////////////////////////
  // Detectors

  logic [9:0]    sfd_ok_w;
  logic          warn_w;
  logic [15:0]   eng_in_w;
  logic          seq_match_w, seq_hit_w, tmo_hit_w, mon_hit_w, live_w, exit_w;
  logic [CW-1:0] seq_lim_w, tmo_lim_w;
  logic [5:0]    nxt_w, nxt_idx_w;
  logic          do_wr_w, wr_ok_w;
  logic [9:0]    flt_clr_w;
  sse_pkg::sse_cfg_s fetch_cfg_w;

  // Fetched words seen as one state definition
  assign fetch_cfg_w = sse_pkg::sse_cfg_s'(fetch_r);

  // Engine input vector: supplies, digital pins, warning
  assign sfd_ok_w    = ~(sfd_uv_in | sfd_ov_in);
  assign warn_w      = (|adc_flag_r) | (|sec_warn_in);
  assign eng_in_w    = {warn_w, dual_function_input_in, sfd_ok_w};
  assign seq_lim_w   = dly_cyc(cfg_r.seq_dly, sse_pkg::SEQ_MIN_U, sse_pkg::SEQ_MAX_U);
  assign tmo_lim_w   = dly_cyc(cfg_r.tmo_dly, sse_pkg::TMO_MIN_U, sse_pkg::TMO_MAX_U);
  assign seq_match_w = eng_in_w[cfg_r.seq_sel] == cfg_r.seq_lvl;
  assign seq_hit_w   = (seq_match_w && seq_cyc_r >= seq_lim_w) || jump_r;
  assign tmo_hit_w   = (cfg_r.tmo_dly != 16'h0000) && (tmo_cyc_r >= tmo_lim_w);
  assign mon_hit_w   = |(cfg_r.mon_mask & (eng_in_w ^ cfg_r.mon_exp));
  assign live_w      = (st_r == sse_pkg::ST_RUN) && run_r;
  assign exit_w      = live_w && (mon_hit_w || tmo_hit_w || seq_hit_w);

  // Exit selection by priority
  assign nxt_w = mon_hit_w ? cfg_r.mon_next :
                 (tmo_hit_w ? cfg_r.tmo_next : cfg_r.seq_next);
  assign nxt_idx_w = (nxt_w >= sse_pkg::NUM_STATES) ? 6'h00 : nxt_w;

  ////////////////////////////////////////////////////////////////////////////
  // Engine sequencing

  // Idle, download, run
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r     <= sse_pkg::ST_IDLE;
      cur_r    <= 6'h00;
      ld_cnt_r <= 12'h000;
      fetch_r  <= '0;
      cfg_r    <= '0;
    end else begin
      unique case (st_r)
        sse_pkg::ST_IDLE: begin
          cur_r    <= 6'h00;
          ld_cnt_r <= 12'h000;
          if (run_r) begin
            st_r <= sse_pkg::ST_LOAD;
          end
        end
        sse_pkg::ST_LOAD: begin
          ld_cnt_r <= ld_cnt_r + 12'h001;
          if (ld_cnt_r >= 12'h001 && ld_cnt_r <= 12'h004) begin
            fetch_r <= {mem_rd_w, fetch_r[127:32]};
          end
          if (!run_r) begin
            st_r <= sse_pkg::ST_IDLE;
          end else if (ld_cnt_r == 12'(LD_LAST)) begin
            st_r  <= sse_pkg::ST_RUN;
            cfg_r <= fetch_cfg_w;
          end
        end
        sse_pkg::ST_RUN: begin
          if (!run_r) begin
            st_r <= sse_pkg::ST_IDLE;
          end else if (exit_w) begin
            st_r     <= sse_pkg::ST_LOAD;
            cur_r    <= nxt_idx_w;
            ld_cnt_r <= 12'h000;
          end
        end
        default: begin
          st_r <= sse_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Sequence and timeout timers, cleared outside run
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seq_cyc_r <= '0;
      tmo_cyc_r <= '0;
    end else if (st_r != sse_pkg::ST_RUN) begin
      seq_cyc_r <= '0;
      tmo_cyc_r <= '0;
    end else begin
      if (!seq_match_w) begin
        seq_cyc_r <= '0;
      end else if (seq_cyc_r != '1) begin
        seq_cyc_r <= seq_cyc_r + 1'b1;
      end
      if (tmo_cyc_r != '1) begin
        tmo_cyc_r <= tmo_cyc_r + 1'b1;
      end
    end
  end

  // Output pins take the new state's levels as it takes effect
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pdo_r <= 10'h000;
    end else if (st_r == sse_pkg::ST_IDLE) begin
      pdo_r <= 10'h000;
    end else if (st_r == sse_pkg::ST_LOAD && run_r && ld_cnt_r == 12'(LD_LAST)) begin
      pdo_r <= fetch_cfg_w.out_lvl;
    end
  end

  // Jump request pending until an exit consumes it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      jump_r <= 1'b0;
    end else if (do_wr_w && awaddr_r == sse_pkg::A_JUMP && wstrb_r[0] && wdata_r[0]) begin
      jump_r <= 1'b1;
    end else if (exit_w) begin
      jump_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch and status

  // Sticky faults, set wins over clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flt_r <= 10'h000;
    end else begin
      flt_r <= (flt_r & ~flt_clr_w)
             | ((live_w && cfg_r.latch_en) ? ~sfd_ok_w : 10'h000);
    end
  end

  // Live status and ADC limit compare
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      uv_r       <= 10'h000;
      ov_r       <= 10'h000;
      adc_flag_r <= 13'h0000;
    end else begin
      uv_r <= sfd_uv_in;
      ov_r <= sfd_ov_in;
      if (adc_in.valid && adc_in.chan < 4'(sse_pkg::NUM_ADC)) begin
        adc_flag_r[adc_in.chan] <= lim_r[adc_in.chan][12]
            ? (adc_in.code > lim_r[adc_in.chan][11:0])
            : (adc_in.code < lim_r[adc_in.chan][11:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign do_wr_w   = !awready_r && !wready_r && !bvalid_r;
  assign wr_ok_w   = addr_ok(awaddr_r);
  assign flt_clr_w = (do_wr_w && wstrb_r[0] && awaddr_r == sse_pkg::A_FLO) ?
                     {2'h0, wdata_r[7:0]} :
                     ((do_wr_w && wstrb_r[0] && awaddr_r == sse_pkg::A_FHI) ?
                     {wdata_r[1:0], 8'h00} : 10'h000);

  // Write address, data and response
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= sse_pkg::RESP_OK;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && awready_r) begin
        awready_r <= 1'b0;
        awaddr_r  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && wready_r) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata_in;
        wstrb_r  <= s_axi_wstrb_in;
      end
      if (do_wr_w) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok_w ? sse_pkg::RESP_OK : sse_pkg::RESP_ERR;
      end
      if (bvalid_r && s_axi_bready_in) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Control and limit registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_r <= sse_pkg::RUN_RST;
      for (int i = 0; i < sse_pkg::NUM_ADC; i++) begin
        lim_r[i] <= sse_pkg::LIM_RST;
      end
    end else if (do_wr_w && wr_ok_w) begin
      if (awaddr_r == sse_pkg::A_CTRL && wstrb_r[0]) begin
        run_r <= wdata_r[0];
      end
      if (awaddr_r[11:6] == sse_pkg::A_LIM[11:6]) begin
        if (wstrb_r[0]) begin
          lim_r[awaddr_r[5:2]][7:0] <= wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
          lim_r[awaddr_r[5:2]][12:8] <= wdata_r[12:8];
        end
      end
    end
  end

  // Read channel
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= sse_pkg::RESP_OK;
    end else if (s_axi_arvalid_in && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= addr_ok(s_axi_araddr_in) ? sse_pkg::RESP_OK : sse_pkg::RESP_ERR;
      unique case (s_axi_araddr_in)
        sse_pkg::A_CTRL:  rdata_r <= {31'h0, run_r};
        sse_pkg::A_STATE: rdata_r <= {23'h0, st_r == sse_pkg::ST_RUN, 2'h0, cur_r};
        sse_pkg::A_FLO:   rdata_r <= {24'h0, flt_r[7:0]};
        sse_pkg::A_FHI:   rdata_r <= {30'h0, flt_r[9:8]};
        sse_pkg::A_SUVOV: rdata_r <= {6'h0, ov_r, 6'h0, uv_r};
        sse_pkg::A_SADC:  rdata_r <= {15'h0, warn_w, 3'h0, adc_flag_r};
        default: begin
          if (addr_ok(s_axi_araddr_in) && s_axi_araddr_in[11:6] == sse_pkg::A_LIM[11:6]) begin
            rdata_r <= {19'h0, lim_r[s_axi_araddr_in[5:2]]};
          end else begin
            rdata_r <= 32'h0000_0000;
          end
        end
      endcase
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Program store
  sse_cfg_mem #(.AW(8), .DW(32)) u_mem (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .wr_en_in    (do_wr_w && wr_ok_w && awaddr_r[11:10] == sse_pkg::A_CFG[11:10]),
    .wr_be_in    (wstrb_r),
    .wr_addr_in  (awaddr_r[9:2]),
    .wr_data_in  (wdata_r),
    .rd_addr_in  ({cur_r, ld_cnt_r[1:0]}),
    .rd_data_out (mem_rd_w)
  );

  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out  = wready_r;
  assign s_axi_bvalid_out  = bvalid_r;
  assign s_axi_bresp_out   = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rdata_out   = rdata_r;
  assign s_axi_rresp_out   = rresp_r;
  assign programmable_output_pin_out = pdo_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_warn_or: assert property (
    warn_w == ((|adc_flag_r) || (|sec_warn_in))) else $error("warning not OR of sources");
  a_mon_first: assert property (
    live_w && mon_hit_w |=> st_r == sse_pkg::ST_LOAD && cur_r == $past(nxt_idx_w)
    && $past(nxt_w) == $past(cfg_r.mon_next)) else $error("monitor exit missed");
  a_tmo_next: assert property (
    live_w && !mon_hit_w && tmo_hit_w |=> cur_r == $past(cfg_r.tmo_next)
    || $past(cfg_r.tmo_next) >= sse_pkg::NUM_STATES) else $error("timeout exit wrong");
  a_seq_next: assert property (
    live_w && !mon_hit_w && !tmo_hit_w && seq_hit_w |=> st_r == sse_pkg::ST_LOAD
    && (cur_r == $past(cfg_r.seq_next) || cur_r == 6'h00)) else $error("seq exit wrong");
  a_seq_reset: assert property (
    st_r == sse_pkg::ST_RUN && !seq_match_w |=> seq_cyc_r == '0) else $error("no restart");
  a_load_lat: assert property (
    st_r == sse_pkg::ST_RUN && $past(st_r) == sse_pkg::ST_LOAD
    |-> $past(ld_cnt_r) == LD_LAST) else $error("download latency wrong");
  a_pin_entry: assert property (
    st_r == sse_pkg::ST_RUN && $past(st_r) == sse_pkg::ST_LOAD
    |-> pdo_r == cfg_r.out_lvl) else $error("pins not set on entry");
  a_latch_keep: assert property (
    flt_clr_w == 10'h000 |=> (flt_r & $past(flt_r)) == $past(flt_r)) else $error("fault lost");
  a_latch_gate: assert property (
    !(live_w && cfg_r.latch_en) && flt_clr_w == 10'h000 |=> flt_r == $past(flt_r))
    else $error("latch captured while disabled");
  a_tmr_entry: assert property (
    st_r == sse_pkg::ST_RUN && $past(st_r) == sse_pkg::ST_LOAD
    |-> seq_cyc_r == '0 && tmo_cyc_r == '0)
    else $error("timers not cleared");

  c_seq_exit: cover property (live_w && seq_hit_w && !tmo_hit_w && !mon_hit_w);
  c_tmo_exit: cover property (live_w && tmo_hit_w && !mon_hit_w);
  c_mon_exit: cover property (live_w && mon_hit_w);
  c_jump:     cover property (live_w && jump_r);

endmodule

/* test/sse_supply_model.sv */
// Far-side model: supply comparators, digital pins and warning sources
`timescale 1ns/100ps
module sse_supply_model (
  // Requested conditions
  input  wire logic [9:0] ok_in,
  input  wire logic [4:0] dig_in,
  input  wire logic [4:0] warn_in,
  input  wire sse_pkg::sse_adc_s adc_req_in,
  // Comparator and pin outputs
  output logic [9:0]        uv_out,
  output logic [9:0]        ov_out,
  output logic [4:0]        dig_out,
  output logic [4:0]        warn_out,
  output sse_pkg::sse_adc_s adc_out
);
  // A supply that is not good shows as an undervoltage trip
  assign uv_out   = ~ok_in;
  assign ov_out   = 10'h000;
  assign dig_out  = dig_in;
  assign warn_out = warn_in;
  // One ADC result per requested pulse
  assign adc_out  = adc_req_in;
endmodule

/* test/testbench.sv */
// Self-checking bench for the sequencing engine
`timescale 1ns/100ps
module testbench;
  logic clk_in = 1'b0, nrst_in = 1'b0;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd_w;
  logic awr, wr_r, bv, arr, rv;
  logic [1:0] br, rr;
  logic [9:0] ok = 10'h001, uv, ov, pins;
  logic [4:0] dg = '0, wn = '0, dgo, wno;
  sse_pkg::sse_adc_s adc, adc_rq = '0;
  logic [33:0] expq[$];
  int err_total = 0, checked = 0;
  logic [31:0] cfg [16] = '{32'h0001_0030, 0, 32'h0001_0000, 0,
    32'h0001_0011, 32'h0028_0002, 32'h0001_0000, 0,
    32'h0001_0011, 32'h0000_0040, 32'h0004_0003, 32'h0001_0001,
    32'h0001_0011, 0, 32'h0008_0000, 0};
  initial forever #2.5 clk_in = ~clk_in;
  sse_engine #(.DLY_UNIT_CYC(2), .LOAD_CYC(8)) u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa), .s_axi_awready_out(awr),
    .s_axi_wvalid_in(wv), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wready_out(wr_r),
    .s_axi_bvalid_out(bv), .s_axi_bresp_out(br), .s_axi_bready_in(bre),
    .s_axi_arvalid_in(arv), .s_axi_araddr_in(ara), .s_axi_arready_out(arr),
    .s_axi_rvalid_out(rv), .s_axi_rdata_out(rd_w), .s_axi_rresp_out(rr),
    .s_axi_rready_in(rre), .sfd_uv_in(uv), .sfd_ov_in(ov), .dual_function_input_in(dgo),
    .sec_warn_in(wno), .adc_in(adc), .programmable_output_pin_out(pins));
  sse_supply_model u_far (.ok_in(ok), .dig_in(dg), .warn_in(wn), .adc_req_in(adc_rq),
    .uv_out(uv), .ov_out(ov),
    .dig_out(dgo), .warn_out(wno), .adc_out(adc));
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bre <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    chk("write response", br, sse_pkg::RESP_OK);
    bre <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    expq.push_back(e);
    arv <= 1'b1; ara <= a; rre <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rre <= 1'b0;
    @(posedge clk_in);
  endtask
  // Watcher: each read answer against the oldest note
  always @(posedge clk_in) begin
    if (rv && rre) begin
      if (expq.size() == 0) chk("unexpected read", {rr, rd_w}, '0);
      else chk("read", {rr, rd_w}, expq.pop_front());
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  initial begin
    void'($urandom(99061));
    repeat (16) @(posedge clk_in);
    ok <= (10'($urandom()) & 10'h3FC) | 10'h001;
    dg <= 5'($urandom());
    wn <= 5'($urandom());
    nrst_in <= 1'b1;
    @(posedge clk_in);
    rd(sse_pkg::A_CTRL, {sse_pkg::RESP_OK, 32'h0});
    rd(12'h0FC, {sse_pkg::RESP_ERR, 32'h0});
    rd(sse_pkg::A_SUVOV, {sse_pkg::RESP_OK, 22'h0, ~ok});
    rd(sse_pkg::A_SADC, {sse_pkg::RESP_OK, 15'h0, |wn, 16'h0});
    wr(sse_pkg::A_LIM + 12'h008, 32'h0000_0800);
    rd(sse_pkg::A_LIM + 12'h008, {sse_pkg::RESP_OK, 32'h800});
    adc_rq <= '{valid: 1'b1, chan: 4'h2, code: 12'h100};
    @(posedge clk_in);
    adc_rq <= '0;
    rd(sse_pkg::A_SADC, {sse_pkg::RESP_OK, 15'h0, 1'b1, 3'h0, 13'h0004});
    $display("test registers done");
    for (int i = 0; i < 16; i++) wr(sse_pkg::A_CFG + 12'(4 * i), cfg[i]);
    wr(sse_pkg::A_CTRL, 32'h1);
    repeat (30) @(posedge clk_in);
    rd(sse_pkg::A_STATE, {sse_pkg::RESP_OK, 32'h101});
    chk("pins state1", pins, 10'h001);
    repeat (100) @(posedge clk_in);
    rd(sse_pkg::A_STATE, {sse_pkg::RESP_OK, 32'h102});
    chk("pins state2", pins, 10'h004);
    $display("test sequence and timeout done");
    ok[0] <= 1'b0;
    repeat (30) @(posedge clk_in);
    chk("pins state3", pins, 10'h008);
    ok[0] <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(sse_pkg::A_FLO, {sse_pkg::RESP_OK, 24'h0, ~ok[7:1], 1'b1});
    rd(sse_pkg::A_FHI, {sse_pkg::RESP_OK, 30'h0, ~ok[9:8]});
    wr(sse_pkg::A_FLO, 32'h0000_00FF);
    rd(sse_pkg::A_FLO, {sse_pkg::RESP_OK, 32'h0});
    ok[0] <= 1'b0;
    wr(sse_pkg::A_JUMP, 32'h1);
    repeat (30) @(posedge clk_in);
    rd(sse_pkg::A_STATE, {sse_pkg::RESP_OK, 32'h100});
    chk("pins state0", pins, 10'h001);
    $display("test monitor latch jump done");
    close_out();
  end
endmodule
